// >>> cfg_device_end.sv
`timescale 1ns/1ns

module cfg_token_fifo #(
    parameter int WIDTH = 41,
    parameter int DEPTH = 8
) (
    input wire logic i_ref_clk,              // Clock
    input wire logic i_srst,                 // Sync reset
    input wire logic i_ce,                   // Clock enable
    input wire logic i_in_valid,             // Write valid
    output logic o_in_ready,                 // Room left
    input wire logic [WIDTH-1:0] i_in_data,  // Write data
    output logic o_out_valid,                // Data present
    input wire logic i_out_ready,            // Read strobe
    output logic [WIDTH-1:0] o_out_data      // Read data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_valid = (count != '0);
    assign o_out_data = mem[rd_ptr];

    always_comb begin
        next_count = count;
        if (push && !pop) begin
            next_count = count + 1'b1;
        end else if (pop && !push) begin
            next_count = count - 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            count <= '0;
            o_in_ready <= 1'b1;
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else if (i_ce) begin
            count <= next_count;
            o_in_ready <= (next_count != (AW+1)'(DEPTH));
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
            end
        end
    end

    for (genvar g = 0; g < DEPTH; g++) begin : g_entry
        always_ff @(posedge i_ref_clk) begin
            if (i_ce && push && wr_ptr == AW'(g)) begin
                mem[g] <= i_in_data;
            end
        end
    end
endmodule // cfg_token_fifo

module cfg_device_end
    import cfg_msg_pkg::*;
#(
    parameter logic [15:0] TILE_ID = DEF_TILE_ID,
    parameter logic [15:0] NODE_ID = DEF_NODE_ID,
    parameter int NREGS = BANK_REGS,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic i_ref_clk,          // Clock
    input wire logic i_srst,             // Sync reset
    input wire logic i_ce,               // Clock enable
    cfg_link_if.device link,             // Token link
    input wire logic i_ps_valid,         // Status access request
    input wire logic i_ps_write,         // 1 write, 0 read
    input wire logic [31:0] i_ps_rid,    // Status resource id
    input wire logic [31:0] i_ps_wdata,  // Status write word
    output logic o_ps_ack,               // Access done pulse
    output logic o_ps_ok,                // Register existed
    output logic [31:0] o_ps_rdata       // Status read word
);
    localparam int IW = (NREGS > 1) ? $clog2(NREGS) : 1;
    localparam int FW = DEST_W + TOK_W;

    typedef enum logic [2:0] {
        S_CMD, S_RET, S_REG, S_DATA, S_END, S_DRAIN, S_REPLY
    } dev_state_t;

    dev_state_t state;
    logic [WORD_W-1:0] regs [2][NREGS];
    logic f_valid;
    logic f_ready;
    logic [FW-1:0] f_data;
    logic [TOK_W-1:0] tok;
    logic [DEST_W-1:0] dest;
    logic take;
    logic is_end;
    logic is_wr;
    logic bank_node;
    logic bank_hit;
    logic [RET_W-1:0] ret_id;
    logic [REGNUM_W-1:0] reg_num;
    logic [WORD_W-1:0] wdata;
    logic [1:0] cnt;
    logic msg_done;
    logic msg_ok;
    logic msg_we;
    logic suppress;
    logic rep_ok;
    logic [2:0] rep_idx;
    logic [2:0] rep_last;
    logic [WORD_W-1:0] rep_sh;
    logic rsp_valid;
    logic [TOK_W-1:0] rsp_tok;
    logic [RET_W-1:0] rsp_dest;
    logic ps_hit;
    logic [IW-1:0] ps_idx;
    logic ps_take;

    // ------------------------------------------------------------
    // Request buffer
    // ------------------------------------------------------------
    cfg_token_fifo #(.WIDTH(FW), .DEPTH(DEPTH)) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_in_valid(link.req_valid),
        .o_in_ready(link.req_ready),
        .i_in_data({link.req_dest, link.req_tok}),
        .o_out_valid(f_valid),
        .i_out_ready(f_ready),
        .o_out_data(f_data)
    );

    assign f_ready = (state != S_REPLY);
    assign tok = f_data[TOK_W-1:0];
    assign dest = f_data[FW-1:TOK_W];
    assign take = i_ce && f_valid && f_ready;
    assign is_end = tok[TOK_CTRL_BIT] && tok[7:0] == TK_END;
    assign msg_done = take && is_end && state != S_CMD;
    assign msg_ok = (state == S_END) && bank_hit
        && (reg_num < REGNUM_W'(NREGS));
    assign msg_we = msg_done && msg_ok && is_wr;
    assign suppress = is_wr && ret_id[7:0] == SUPPRESS_BYTE;

    assign link.rsp_valid = rsp_valid;
    assign link.rsp_tok = rsp_tok;
    assign link.rsp_dest = rsp_dest;

    // ------------------------------------------------------------
    // Message parser and reply sender
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state <= S_CMD;
            is_wr <= 1'b0;
            bank_node <= 1'b0;
            bank_hit <= 1'b0;
            ret_id <= '0;
            reg_num <= '0;
            wdata <= '0;
            cnt <= '0;
            rep_ok <= 1'b0;
            rep_idx <= '0;
            rep_last <= '0;
            rep_sh <= '0;
            rsp_valid <= 1'b0;
            rsp_tok <= '0;
            rsp_dest <= '0;
        end else if (i_ce) begin
            if (rsp_valid && link.rsp_ready) begin
                rsp_valid <= 1'b0;
            end
            if (take) begin
                cnt <= cnt + 1'b1;
                unique case (state)
                    S_CMD: begin
                        cnt <= '0;
                        if (tok[TOK_CTRL_BIT] && (tok[7:0] == TK_WRITE
                                || tok[7:0] == TK_READ)) begin
                            is_wr <= (tok[7:0] == TK_WRITE);
                            bank_node <= (dest[15:0] == NODE_PATTERN);
                            bank_hit <= (dest == {TILE_ID, TILE_PATTERN})
                                || (dest == {NODE_ID, NODE_PATTERN});
                            state <= S_RET;
                        end
                    end
                    S_RET: begin
                        ret_id <= {ret_id[RET_W-9:0], tok[7:0]};
                        if (cnt == 2'(RET_BYTES-1)) begin
                            cnt <= '0;
                            state <= S_REG;
                        end
                    end
                    S_REG: begin
                        reg_num <= {reg_num[7:0], tok[7:0]};
                        if (cnt == 2'(REG_BYTES-1)) begin
                            cnt <= '0;
                            state <= is_wr ? S_DATA : S_END;
                        end
                    end
                    S_DATA: begin
                        wdata <= {wdata[WORD_W-9:0], tok[7:0]};
                        if (cnt == 2'(DATA_BYTES-1)) begin
                            state <= S_END;
                        end
                    end
                    S_END, S_DRAIN: begin
                    end
                    S_REPLY: begin
                    end
                endcase
                if (state != S_CMD && tok[TOK_CTRL_BIT] && !is_end) begin
                    state <= S_DRAIN;
                end
                if (state != S_CMD && state != S_DRAIN
                        && !tok[TOK_CTRL_BIT] && state == S_END) begin
                    state <= S_DRAIN;
                end
                if (msg_done) begin
                    rep_ok <= msg_ok;
                    rep_idx <= '0;
                    rep_last <= (msg_ok && !is_wr) ? 3'h5 : 3'h1;
                    rep_sh <= regs[bank_node][reg_num[IW-1:0]];
                    state <= suppress ? S_CMD : S_REPLY;
                end
            end
            if (state == S_REPLY && (!rsp_valid || link.rsp_ready)) begin
                rsp_valid <= 1'b1;
                rsp_dest <= ret_id;
                rep_idx <= rep_idx + 1'b1;
                if (rep_idx == '0) begin
                    rsp_tok <= {1'b1, rep_ok ? TK_OK : TK_FAIL};
                end else if (rep_idx == rep_last) begin
                    rsp_tok <= {1'b1, TK_END};
                    state <= S_CMD;
                end else begin
                    rsp_tok <= {1'b0, rep_sh[WORD_W-1 -: 8]};
                    rep_sh <= {rep_sh[WORD_W-9:0], 8'h00};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Local status access
    // ------------------------------------------------------------
    assign ps_hit = i_ps_rid[7:0] == PS_RES_TYPE
        && i_ps_rid[31:PS_SHIFT] < (32-PS_SHIFT)'(NREGS);
    assign ps_idx = i_ps_rid[PS_SHIFT +: IW];
    assign ps_take = i_ps_valid && !msg_we && !o_ps_ack;

    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            o_ps_ack <= 1'b0;
            o_ps_ok <= 1'b0;
            o_ps_rdata <= '0;
        end else if (i_ce) begin
            o_ps_ack <= ps_take;
            if (ps_take) begin
                o_ps_ok <= ps_hit;
                o_ps_rdata <= ps_hit ? regs[0][ps_idx] : '0;
            end
        end
    end

    // ------------------------------------------------------------
    // Register banks: 0 tile, 1 node
    // ------------------------------------------------------------
    for (genvar b = 0; b < 2; b++) begin : g_bank
        for (genvar e = 0; e < NREGS; e++) begin : g_reg
            always_ff @(posedge i_ref_clk) begin
                if (i_srst) begin
                    regs[b][e] <= REG_RST;
                end else if (i_ce) begin
                    if (msg_we && bank_node == 1'(b)
                            && reg_num[IW-1:0] == IW'(e)) begin
                        regs[b][e] <= wdata;
                    end else if (b == 0 && ps_take && ps_hit && i_ps_write
                            && ps_idx == IW'(e)) begin
                        regs[b][e] <= i_ps_wdata;
                    end
                end
            end
        end
    end
endmodule // cfg_device_end

// >>> cfg_msg_pkg.sv
package cfg_msg_pkg;
    // ------------------------------------------------------------
    // Token and field layout
    // ------------------------------------------------------------
    localparam int TOK_W = 9;             // Bit 8 marks a control token
    localparam int TOK_CTRL_BIT = 8;
    localparam int RET_W = 24;
    localparam int REGNUM_W = 16;
    localparam int WORD_W = 32;
    localparam int DEST_W = 32;
    localparam int RET_BYTES = 3;
    localparam int REG_BYTES = 2;
    localparam int DATA_BYTES = 4;
    localparam int MSG_SH_W = RET_W + REGNUM_W + WORD_W;
    localparam logic [3:0] WR_BYTES = 4'h9;
    localparam logic [3:0] RD_BYTES = 4'h5;

    // ------------------------------------------------------------
    // Control token values
    // ------------------------------------------------------------
    localparam logic [7:0] TK_WRITE = 8'hC0;
    localparam logic [7:0] TK_READ = 8'hC1;
    localparam logic [7:0] TK_END = 8'h01;
    localparam logic [7:0] TK_OK = 8'h03;
    localparam logic [7:0] TK_FAIL = 8'h04;

    // ------------------------------------------------------------
    // Destinations and identifiers
    // ------------------------------------------------------------
    localparam logic [15:0] TILE_PATTERN = 16'hC20C;
    localparam logic [15:0] NODE_PATTERN = 16'hC30C;
    localparam logic [7:0] SUPPRESS_BYTE = 8'hFF;
    localparam logic [7:0] PS_RES_TYPE = 8'h0B;
    localparam int PS_SHIFT = 8;
    localparam logic [15:0] DEF_TILE_ID = 16'h0000;  // Arbitrary value
    localparam logic [15:0] DEF_NODE_ID = 16'h0001;  // Arbitrary value

    // ------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------
    localparam int FIFO_DEPTH = 8;
    localparam int BANK_REGS = 8;
    localparam logic [31:0] REG_RST = 32'h00000000;
endpackage

// >>> cfg_link_if.sv
`timescale 1ns/1ns
interface cfg_link_if;
    import cfg_msg_pkg::*;
    logic req_valid;
    logic req_ready;
    logic [TOK_W-1:0] req_tok;
    logic [DEST_W-1:0] req_dest;
    logic rsp_valid;
    logic rsp_ready;
    logic [TOK_W-1:0] rsp_tok;
    logic [RET_W-1:0] rsp_dest;

    modport device (
        input req_valid, req_tok, req_dest, rsp_ready,
        output req_ready, rsp_valid, rsp_tok, rsp_dest
    );
    modport requester (
        output req_valid, req_tok, req_dest, rsp_ready,
        input req_ready, rsp_valid, rsp_tok, rsp_dest
    );
endinterface

// >>> cfg_requester_end.sv
`timescale 1ns/1ns
module cfg_requester_end
    import cfg_msg_pkg::*;
(
    input wire logic i_ref_clk,            // Clock
    input wire logic i_srst,               // Sync reset
    input wire logic i_ce,                 // Clock enable
    cfg_link_if.requester link,            // Token link
    input wire logic i_cmd_valid,          // Start a message
    input wire logic i_cmd_write,          // 1 write, 0 read
    input wire logic i_cmd_node,           // 1 node bank, 0 tile bank
    input wire logic [15:0] i_cmd_target,  // Tile or node identifier
    input wire logic [23:0] i_cmd_ret,     // Return channel-end id
    input wire logic [15:0] i_cmd_reg,     // Register number
    input wire logic [31:0] i_cmd_wdata,   // Write word
    output logic o_cmd_ready,              // Idle, command taken
    output logic o_done,                   // Message finished pulse
    output logic o_done_ok,                // Success token seen, or quiet write sent
    output logic o_done_replied,           // A reply came back
    output logic [31:0] o_done_rdata       // Read word
);
    typedef enum logic [1:0] {Q_IDLE, Q_SEND, Q_WAIT} req_state_t;

    req_state_t state;
    logic [MSG_SH_W-1:0] sh;
    logic [3:0] left;
    logic quiet;
    logic req_valid;
    logic [TOK_W-1:0] req_tok;
    logic [DEST_W-1:0] req_dest;
    logic rsp_ready;

    assign link.req_valid = req_valid;
    assign link.req_tok = req_tok;
    assign link.req_dest = req_dest;
    assign link.rsp_ready = rsp_ready;

    // ------------------------------------------------------------
    // Sender and reply collector
    // ------------------------------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            state <= Q_IDLE;
            sh <= '0;
            left <= '0;
            quiet <= 1'b0;
            req_valid <= 1'b0;
            req_tok <= '0;
            req_dest <= '0;
            rsp_ready <= 1'b0;
            o_cmd_ready <= 1'b1;
            o_done <= 1'b0;
            o_done_ok <= 1'b0;
            o_done_replied <= 1'b0;
            o_done_rdata <= '0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            rsp_ready <= 1'b1;
            unique case (state)
                Q_IDLE: begin
                    if (i_cmd_valid) begin
                        req_valid <= 1'b1;
                        req_tok <= {1'b1, i_cmd_write ? TK_WRITE : TK_READ};
                        req_dest <= {i_cmd_target,
                            i_cmd_node ? NODE_PATTERN : TILE_PATTERN};
                        sh <= {i_cmd_ret, i_cmd_reg, i_cmd_wdata};
                        left <= i_cmd_write ? WR_BYTES : RD_BYTES;
                        quiet <= i_cmd_write
                            && i_cmd_ret[7:0] == SUPPRESS_BYTE;
                        o_done_ok <= 1'b0;
                        o_done_rdata <= '0;
                        o_cmd_ready <= 1'b0;
                        state <= Q_SEND;
                    end
                end
                Q_SEND: begin
                    if (link.req_ready) begin
                        if (left != '0) begin
                            req_tok <= {1'b0, sh[MSG_SH_W-1 -: 8]};
                            sh <= {sh[MSG_SH_W-9:0], 8'h00};
                            left <= left - 1'b1;
                        end else if (req_tok != {1'b1, TK_END}) begin
                            req_tok <= {1'b1, TK_END};
                        end else begin
                            req_valid <= 1'b0;
                            if (quiet) begin
                                o_done <= 1'b1;
                                o_done_ok <= 1'b1;
                                o_done_replied <= 1'b0;
                                o_cmd_ready <= 1'b1;
                                state <= Q_IDLE;
                            end else begin
                                state <= Q_WAIT;
                            end
                        end
                    end
                end
                Q_WAIT: begin
                    if (link.rsp_valid && rsp_ready) begin
                        if (!link.rsp_tok[TOK_CTRL_BIT]) begin
                            o_done_rdata <= {o_done_rdata[23:0],
                                link.rsp_tok[7:0]};
                        end else if (link.rsp_tok[7:0] == TK_OK) begin
                            o_done_ok <= 1'b1;
                        end else if (link.rsp_tok[7:0] == TK_END) begin
                            o_done <= 1'b1;
                            o_done_replied <= 1'b1;
                            o_cmd_ready <= 1'b1;
                            state <= Q_IDLE;
                        end else begin
                            o_done_ok <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end
endmodule // cfg_requester_end

// >>> cfg_link_assertions.sv
`timescale 1ns/1ns
module cfg_link_assertions
    import cfg_msg_pkg::*;
(
    input wire logic i_ref_clk,              // Clock
    input wire logic i_srst,                 // Sync reset
    input wire logic req_valid,              // Request valid
    input wire logic req_ready,              // Request ready
    input wire logic [TOK_W-1:0] req_tok,    // Request token
    input wire logic [DEST_W-1:0] req_dest,  // Destination
    input wire logic rsp_valid,              // Reply valid
    input wire logic rsp_ready,              // Reply ready
    input wire logic [TOK_W-1:0] rsp_tok,    // Reply token
    input wire logic [RET_W-1:0] rsp_dest    // Reply return id
);
    localparam logic [8:0] T_WR = {1'b1, TK_WRITE};
    localparam logic [8:0] T_RD = {1'b1, TK_READ};
    localparam logic [8:0] T_END = {1'b1, TK_END};
    localparam logic [8:0] T_OK = {1'b1, TK_OK};
    localparam logic [8:0] T_FAIL = {1'b1, TK_FAIL};
    logic req_acc;
    logic rsp_acc;
    logic req_wr;
    logic [3:0] req_cnt;
    logic [7:0] ret_lo;
    logic [8:0] last_rsp;
    logic [2:0] data_cnt;
    logic [RET_W-1:0] rsp_id;
    assign req_acc = req_valid && req_ready;
    assign rsp_acc = rsp_valid && rsp_ready;
    // --------
    // Token tracking
    // --------
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            req_cnt <= 4'h0;
            req_wr <= 1'b0;
            ret_lo <= 8'h00;
        end else if (req_acc) begin
            req_cnt <= (req_tok == T_END) ? 4'h0 : req_cnt + 4'h1;
            if (req_cnt == 4'h0) req_wr <= (req_tok == T_WR);
            if (req_cnt == 4'h3) ret_lo <= req_tok[7:0];
        end
    end
    always_ff @(posedge i_ref_clk) begin
        if (i_srst) begin
            last_rsp <= T_END;
            data_cnt <= 3'h0;
            rsp_id <= '0;
        end else if (rsp_acc) begin
            last_rsp <= rsp_tok;
            data_cnt <= rsp_tok[8] ? 3'h0 : data_cnt + 3'h1;
            if (last_rsp == T_END) rsp_id <= rsp_dest;
        end
    end
    // --------
    // Properties
    // --------
    default clocking dcb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    sequence msg_end;
        req_acc && req_tok == T_END;
    endsequence
    sequence no_reply;
        !rsp_valid [*8];
    endsequence
    req_hold_a: assert property (
        req_valid && !req_ready |=> req_valid && $stable(req_tok)
            && $stable(req_dest)) else $error("request dropped");
    msg_head_a: assert property (
        req_valid && req_cnt == 4'h0 |-> (req_tok == T_WR || req_tok == T_RD)
            && (req_dest[15:0] == TILE_PATTERN
            || req_dest[15:0] == NODE_PATTERN)) else $error("bad header");
    end_place_a: assert property (
        req_valid && req_tok == T_END |-> req_cnt == (req_wr ? 4'hA : 4'h6))
        else $error("end token misplaced");
    supp_quiet_a: assert property (
        msg_end ##0 (req_wr && ret_lo == SUPPRESS_BYTE) |=> no_reply)
        else $error("suppressed write replied");
    reply_due_a: assert property (
        msg_end ##0 !(req_wr && ret_lo == SUPPRESS_BYTE)
            |-> ##[3:40] rsp_valid) else $error("no reply");
    rsp_hold_a: assert property (
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_tok)
            && $stable(rsp_dest)) else $error("reply dropped");
    reply_head_a: assert property (
        rsp_valid && last_rsp == T_END |-> rsp_tok == T_OK
            || rsp_tok == T_FAIL) else $error("bad reply head");
    fail_tail_a: assert property (
        rsp_valid && last_rsp == T_FAIL |-> rsp_tok == T_END)
        else $error("fail not closed");
    data_after_ok_a: assert property (
        rsp_valid && !rsp_tok[8] |-> data_cnt < 3'h4
            && (last_rsp == T_OK || !last_rsp[8])) else $error("stray data");
    word_count_a: assert property (
        rsp_valid && rsp_tok == T_END |-> data_cnt == 3'h0
            || data_cnt == 3'h4) else $error("short read word");
    reply_dest_a: assert property (
        rsp_valid && last_rsp != T_END |-> rsp_dest == rsp_id)
        else $error("return id changed");
endmodule // cfg_link_assertions

// >>> tb_config_register_message_access.sv
`timescale 1ns/1ns
module tb_config_register_message_access;
    import cfg_msg_pkg::*;
    logic i_ref_clk = 1'h0, i_srst = 1'h1;
    logic i_cmd_valid = 1'h0, i_cmd_write = 1'h0, i_cmd_node = 1'h0;
    logic [15:0] i_cmd_target = 16'h0, i_cmd_reg = 16'h0;
    logic [23:0] i_cmd_ret = 24'h0;
    logic [31:0] i_cmd_wdata = 32'h0, i_ps_rid = 32'h0, i_ps_wdata = 32'h0;
    logic i_ps_valid = 1'h0, i_ps_write = 1'h0;
    logic o_cmd_ready, o_done, o_done_ok, o_done_replied, o_ps_ack, o_ps_ok;
    logic [31:0] o_done_rdata, o_ps_rdata, r, w;
    logic [31:0] lfsr = 32'h1EB3AB4C;
    logic [31:0] bank [0:1][0:7];
    int num_errors = 0, num_checks = 0, cycles = 0;
    cfg_link_if cfg_link_if_i ();
    cfg_device_end cfg_device_end_i (.i_ref_clk, .i_srst, .i_ce(1'h1),
        .link(cfg_link_if_i), .i_ps_valid, .i_ps_write, .i_ps_rid,
        .i_ps_wdata, .o_ps_ack, .o_ps_ok, .o_ps_rdata);
    cfg_requester_end cfg_requester_end_i (.i_ref_clk, .i_srst, .i_ce(1'h1),
        .link(cfg_link_if_i), .i_cmd_valid, .i_cmd_write, .i_cmd_node,
        .i_cmd_target, .i_cmd_ret, .i_cmd_reg, .i_cmd_wdata, .o_cmd_ready,
        .o_done, .o_done_ok, .o_done_replied, .o_done_rdata);
    cfg_link_assertions cfg_link_assertions_i (.i_ref_clk, .i_srst,
        .req_valid(cfg_link_if_i.req_valid),
        .req_ready(cfg_link_if_i.req_ready), .req_tok(cfg_link_if_i.req_tok),
        .req_dest(cfg_link_if_i.req_dest), .rsp_tok(cfg_link_if_i.rsp_tok),
        .rsp_valid(cfg_link_if_i.rsp_valid), .rsp_dest(cfg_link_if_i.rsp_dest),
        .rsp_ready(cfg_link_if_i.rsp_ready));
    // --------
    // Helpers
    // --------
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string s);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, s);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, exp, input string s);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: %s %h", $time, s, got);
        end
    endtask
    task automatic msg(input logic wr, nd, input logic [15:0] tgt, rg,
        input logic [23:0] ret, input logic [31:0] wd);
        logic hit;
        logic supp;
        int n;
        hit = tgt == (nd ? DEF_NODE_ID : DEF_TILE_ID) && rg < BANK_REGS;
        supp = wr && ret[7:0] == SUPPRESS_BYTE;
        n = 0;
        while (o_cmd_ready !== 1'h1 && n++ < 200) @(negedge i_ref_clk);
        @(posedge i_ref_clk);
        {i_cmd_valid, i_cmd_write, i_cmd_node, i_cmd_target, i_cmd_reg,
            i_cmd_ret, i_cmd_wdata} <= {1'h1, wr, nd, tgt, rg, ret, wd};
        @(posedge i_ref_clk);
        i_cmd_valid <= 1'h0;
        do @(negedge i_ref_clk); while (o_done !== 1'h1 && n++ < 400);
        chk_bit(o_done, 1'h1, "done");
        chk_bit(o_cmd_ready, 1'h1, "ready");
        chk_bit(o_done_replied, !supp, "replied");
        chk_bit(o_done_ok, supp | hit, "ok");
        if (hit && !wr) chk_word(o_done_rdata, bank[nd][rg[2:0]], "rd");
        if (hit && wr) bank[nd][rg[2:0]] = wd;
    endtask
    task automatic ps(input logic wr, input logic [31:0] rid, wd);
        logic hit;
        int n;
        hit = rid[7:0] == PS_RES_TYPE && rid[31:8] < BANK_REGS;
        n = 0;
        @(posedge i_ref_clk);
        {i_ps_valid, i_ps_write, i_ps_rid, i_ps_wdata} <= {1'h1, wr, rid, wd};
        do @(negedge i_ref_clk); while (o_ps_ack !== 1'h1 && n++ < 20);
        chk_bit(o_ps_ack, 1'h1, "ps ack");
        @(posedge i_ref_clk);
        i_ps_valid <= 1'h0;
        chk_bit(o_ps_ok, hit, "ps ok");
        if (hit && !wr) chk_word(o_ps_rdata, bank[0][rid[10:8]], "ps");
        if (hit && wr) bank[0][rid[10:8]] = wd;
    endtask
    // --------
    // Sequence
    // --------
    initial begin
        forever #20 i_ref_clk = ~i_ref_clk;
    end
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        foreach (bank[b, k]) bank[b][k] = REG_RST;
        repeat (20) @(posedge i_ref_clk);
        i_srst <= 1'h0;
        msg(1'h1, 1'h0, DEF_TILE_ID, 16'h0, 24'h123456, 32'hDEADBEEF);
        msg(1'h1, 1'h0, DEF_TILE_ID, 16'h7, 24'h0001FF, 32'h89ABCDEF);
        msg(1'h0, 1'h0, DEF_TILE_ID, 16'h7, 24'h000102, 32'h0);
        msg(1'h1, 1'h1, DEF_NODE_ID, 16'h3, 24'hABCDEF, 32'h01020304);
        msg(1'h0, 1'h1, DEF_NODE_ID, 16'h3, 24'h00AB12, 32'h0);
        msg(1'h0, 1'h0, DEF_TILE_ID, 16'h8, 24'h000001, 32'h0);
        msg(1'h1, 1'h1, DEF_TILE_ID, 16'h1, 24'h000002, 32'h5);
        msg(1'h0, 1'h0, DEF_TILE_ID, 16'h0, 24'h000003, 32'h0);
        $display("test corner done");
        ps(1'h1, 32'h0000020B, 32'hCAFE0123);
        ps(1'h0, 32'h0000020B, 32'h0);
        msg(1'h0, 1'h0, DEF_TILE_ID, 16'h2, 24'h000004, 32'h0);
        ps(1'h1, 32'h0000030C, 32'h1);
        ps(1'h0, 32'h0000080B, 32'h0);
        $display("test status done");
        for (int k = 0; k < 60; k++) begin
            lfsr = next_rand(lfsr);
            r = lfsr;
            lfsr = next_rand(lfsr);
            w = lfsr;
            if (r[10]) ps(r[0], {20'h0, r[14:11], PS_RES_TYPE}, w);
            else msg(r[0], r[1], r[3:0] == 4'h0 ? r[31:16] : (r[1] ?
                DEF_NODE_ID : DEF_TILE_ID), {12'h0, r[7:4]}, r[9] ?
                {r[31:16], SUPPRESS_BYTE} : r[31:8], w);
        end
        $display("test random done");
        conclude();
    end
endmodule // tb_config_register_message_access
